// >>> logic/sec_timer.v
`timescale 1ns/1ns

// seconds counter: held at zero by clear, saturates at all ones so that
// a comparison against a limit of 9999 never wraps
module sec_timer #(
	parameter W = 14
) (
	input wire mclk,
	input wire reset,
	input wire tick,
	input wire clear,
	input wire [W-1:0] limit,
	output reg [W-1:0] count,
	output wire done
);

	// ------------------------------------------------------------------
	// counter
	// ------------------------------------------------------------------
	always @(posedge mclk) begin
		if (reset || clear) begin
			count <= {W{1'b0}};
		end else if (tick && count != {W{1'b1}}) begin
			count <= count + {{(W-1){1'b0}}, 1'b1};
		end
	end

	assign done = (count >= limit);

endmodule // sec_timer

// >>> logic/special_output.v
`timescale 1ns/1ns
`include "special_output_defines.vh"

module special_output #(
	parameter TICK_CYCLES = `SECOND_CYCLES,
	parameter TW = 14,
	parameter SW = 17
) (
	input wire mclk,
	input wire reset,
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	input wire signed [15:0] in_a,
	input wire signed [15:0] in_b,
	output reg signed [15:0] analog_out,
	output reg [2:0] stage_out,
	output reg comp_out
);

	localparam ST_OFF = 2'b00;
	localparam ST_ON = 2'b01;
	localparam ST_DLY = 2'b10;

	reg [1:0] func_reg;
	reg order_reg;
	reg b_conn_reg;
	reg signed [15:0] a_on_reg, a_off_reg, b_on_reg, b_off_reg;
	reg [TW-1:0] min_on_reg, min_off_reg, off_dly_reg, zero_tmo_reg, stage_dly_reg;
	reg [SW-1:0] size1_reg, size2_reg, size3_reg, size4_reg;
	reg [1:0] state_reg, state_next;
	reg [1:0] cnt_reg, cnt_next;
	reg [1:0] rot_reg, rot_next;
	wire tick;

	// ------------------------------------------------------------------
	// register port
	// ------------------------------------------------------------------
	always @(posedge mclk) begin
		if (reset) begin
			func_reg <= `FUNC_OFF;
			order_reg <= 1'b0;
			b_conn_reg <= 1'b0;
			a_on_reg <= `RST_ZERO16;
			a_off_reg <= `RST_ZERO16;
			b_on_reg <= `RST_ZERO16;
			b_off_reg <= `RST_ZERO16;
			min_on_reg <= `RST_ZERO14;
			min_off_reg <= `RST_ZERO14;
			off_dly_reg <= `RST_ZERO14;
			zero_tmo_reg <= `RST_ZERO14;
			stage_dly_reg <= `RST_ZERO14;
			size1_reg <= `RST_ZERO17;
			size2_reg <= `RST_ZERO17;
			size3_reg <= `RST_ZERO17;
			size4_reg <= `RST_ZERO17;
		end else if (reg_wr) begin
			case (reg_addr)
			`OFS_CTRL: begin
				func_reg <= reg_wdata[`CTRL_FUNC_LSB +: 2];
				order_reg <= reg_wdata[`CTRL_ORDER_BIT];
				b_conn_reg <= reg_wdata[`CTRL_B_CONN_BIT];
			end
			`OFS_A_ON: a_on_reg <= reg_wdata[15:0];
			`OFS_A_OFF: a_off_reg <= reg_wdata[15:0];
			`OFS_B_ON: b_on_reg <= reg_wdata[15:0];
			`OFS_B_OFF: b_off_reg <= reg_wdata[15:0];
			`OFS_MIN_ON: min_on_reg <= reg_wdata[TW-1:0];
			`OFS_MIN_OFF: min_off_reg <= reg_wdata[TW-1:0];
			`OFS_OFF_DLY: off_dly_reg <= reg_wdata[TW-1:0];
			`OFS_ZERO_TMO: zero_tmo_reg <= reg_wdata[TW-1:0];
			`OFS_SIZE1: size1_reg <= reg_wdata[SW-1:0];
			`OFS_SIZE2: size2_reg <= reg_wdata[SW-1:0];
			`OFS_SIZE3: size3_reg <= reg_wdata[SW-1:0];
			`OFS_SIZE4: size4_reg <= reg_wdata[SW-1:0];
			`OFS_STAGE_DLY: stage_dly_reg <= reg_wdata[TW-1:0];
			default: ;
			endcase
		end
	end

	// read data one cycle after the strobe; unmapped offsets read zero
	always @(posedge mclk) begin
		if (reset || !reg_rd) begin
			reg_rdata <= 32'h00000000;
		end else begin
			case (reg_addr)
			`OFS_CTRL: reg_rdata <= {23'h000000, b_conn_reg, 3'h0, order_reg, 2'h0, func_reg};
			`OFS_A_ON: reg_rdata <= {{16{a_on_reg[15]}}, a_on_reg};
			`OFS_A_OFF: reg_rdata <= {{16{a_off_reg[15]}}, a_off_reg};
			`OFS_B_ON: reg_rdata <= {{16{b_on_reg[15]}}, b_on_reg};
			`OFS_B_OFF: reg_rdata <= {{16{b_off_reg[15]}}, b_off_reg};
			`OFS_MIN_ON: reg_rdata <= {{(32-TW){1'b0}}, min_on_reg};
			`OFS_MIN_OFF: reg_rdata <= {{(32-TW){1'b0}}, min_off_reg};
			`OFS_OFF_DLY: reg_rdata <= {{(32-TW){1'b0}}, off_dly_reg};
			`OFS_ZERO_TMO: reg_rdata <= {{(32-TW){1'b0}}, zero_tmo_reg};
			`OFS_SIZE1: reg_rdata <= {{(32-SW){1'b0}}, size1_reg};
			`OFS_SIZE2: reg_rdata <= {{(32-SW){1'b0}}, size2_reg};
			`OFS_SIZE3: reg_rdata <= {{(32-SW){1'b0}}, size3_reg};
			`OFS_SIZE4: reg_rdata <= {{(32-SW){1'b0}}, size4_reg};
			`OFS_STAGE_DLY: reg_rdata <= {{(32-TW){1'b0}}, stage_dly_reg};
			`OFS_STATUS: reg_rdata <= {17'h00000, stage_out, 2'h0, rot_reg, 2'h0, cnt_reg,
				2'h0, state_reg == ST_DLY, comp_out};
			default: reg_rdata <= 32'h00000000;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// timebase and timers
	// ------------------------------------------------------------------
	tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
		.mclk(mclk),
		.reset(reset),
		.tick(tick)
	);

	wire min_on_done, min_off_done, off_dly_done, stage_done;
	wire [TW-1:0] zero_cnt;
	wire both_zero;
	wire stage_up;

	sec_timer #(.W(TW)) u_min_on (
		.mclk(mclk), .reset(reset), .tick(tick),
		.clear(state_reg == ST_OFF), .limit(min_on_reg),
		.count(), .done(min_on_done)
	);

	sec_timer #(.W(TW)) u_min_off (
		.mclk(mclk), .reset(reset), .tick(tick),
		.clear(state_reg != ST_OFF), .limit(min_off_reg),
		.count(), .done(min_off_done)
	);

	// cleared whenever the off delay is not running, so renewed demand restarts it
	sec_timer #(.W(TW)) u_off_dly (
		.mclk(mclk), .reset(reset), .tick(tick),
		.clear(state_reg != ST_DLY), .limit(off_dly_reg),
		.count(), .done(off_dly_done)
	);

	sec_timer #(.W(TW)) u_zero (
		.mclk(mclk), .reset(reset), .tick(tick),
		.clear(state_reg == ST_OFF || !both_zero), .limit(zero_tmo_reg),
		.count(zero_cnt), .done()
	);

	sec_timer #(.W(TW)) u_stage (
		.mclk(mclk), .reset(reset), .tick(tick),
		.clear(stage_up), .limit(stage_dly_reg),
		.count(), .done(stage_done)
	);

	// ------------------------------------------------------------------
	// compressor decisions
	// ------------------------------------------------------------------
	// a missing second loop never calls, never holds, and counts as zero
	wire call_a = (in_a <= a_on_reg);
	wire call_b = b_conn_reg && (in_b <= b_on_reg);
	wire need_a = (in_a < a_off_reg);
	wire need_b = b_conn_reg && (in_b < b_off_reg);
	wire need = need_a || need_b;
	assign both_zero = (in_a == 16'h0000) && (!b_conn_reg || in_b == 16'h0000);
	wire zero_trip = (zero_tmo_reg != `RST_ZERO14) && (zero_cnt > zero_tmo_reg);

	// minimum on time also guards the zero-power shutoff to avoid short cycles
	always @* begin
		state_next = state_reg;
		if (func_reg != `FUNC_COMP) begin
			state_next = ST_OFF;
		end else begin
			case (state_reg)
			ST_OFF: begin
				if ((call_a || call_b) && min_off_done) begin
					state_next = ST_ON;
				end
			end
			ST_ON: begin
				if (zero_trip && min_on_done) begin
					state_next = ST_OFF;
				end else if (!need && min_on_done) begin
					state_next = ST_DLY;
				end
			end
			ST_DLY: begin
				if (need) begin
					state_next = ST_ON;
				end else if (off_dly_done || zero_trip) begin
					state_next = ST_OFF;
				end
			end
			default: state_next = ST_OFF;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// sequencer arithmetic
	// ------------------------------------------------------------------
	// demand in tenths of a percent, clipped to the usable span
	wire [10:0] dem = in_a[15] ? 11'h000 :
		(in_a > $signed({5'h00, `PCT_FULL})) ? `PCT_FULL : in_a[10:0];
	wire [19:0] total = {3'h0, size1_reg} + {3'h0, size2_reg} + {3'h0, size3_reg}
		+ {3'h0, size4_reg};
	wire [30:0] prod = dem * total;
	wire [SW-1:0] share [0:2];
	wire [19:0] cum [0:3];
	wire [2:0] reach;
	wire [2:0] stage_on; // registered in one place so each output has a single driver
	assign share[0] = size2_reg;
	assign share[1] = size3_reg;
	assign share[2] = size4_reg;
	assign cum[0] = 20'h00000;

	// position p of the switching order holds stage (rot + p) mod 3
	genvar p;
	generate
		for (p = 0; p < 3; p = p + 1) begin : g_pos
			localparam integer SLOT = p;
			wire [2:0] idx_sum = {1'b0, rot_reg} + SLOT[2:0];
			wire [1:0] idx = (idx_sum >= 3'h3) ? idx_sum[1:0] - 2'h3 : idx_sum[1:0];
			assign cum[p+1] = cum[p] + {3'h0, share[idx]};
			assign reach[p] = (prod >= cum[p+1] * `PCT_FULL);
			wire [2:0] pos_sum = {1'b0, SLOT[1:0]} + 3'h3 - {1'b0, rot_reg};
			wire [1:0] pos = (pos_sum >= 3'h3) ? pos_sum[1:0] - 2'h3 : pos_sum[1:0];
			assign stage_on[p] = (func_reg == `FUNC_SEQ) && (pos < cnt_next);
		end
	endgenerate

	wire [1:0] want = {1'b0, reach[0]} + {1'b0, reach[1]} + {1'b0, reach[2]};
	assign stage_up = (func_reg == `FUNC_SEQ) && (want > cnt_reg) && stage_done;

	// stages come on one at a time, go off one per clock without the stage delay, last on first off
	always @* begin
		cnt_next = cnt_reg;
		rot_next = rot_reg;
		if (func_reg != `FUNC_SEQ) begin
			cnt_next = 2'h0;
		end else if (stage_up) begin
			cnt_next = cnt_reg + 2'h1;
		end else if (want < cnt_reg) begin
			cnt_next = cnt_reg - 2'h1;
			if (order_reg && cnt_reg == 2'h1) begin
				rot_next = (rot_reg == 2'h2) ? 2'h0 : rot_reg + 2'h1;
			end
		end
	end

	// vernier carries what the switched stages do not, scaled to its size
	wire [30:0] sw_pow = cum[cnt_reg] * `PCT_FULL;
	wire [30:0] rem = (prod > sw_pow) ? prod - sw_pow : 31'h00000000;
	wire [30:0] vq = (size1_reg == `RST_ZERO17) ? 31'h00000000 : rem / size1_reg;
	wire [10:0] vern = (vq > {20'h00000, `PCT_FULL}) ? `PCT_FULL : vq[10:0];

	// ------------------------------------------------------------------
	// state and outputs
	// ------------------------------------------------------------------
	always @(posedge mclk) begin
		if (reset) begin
			state_reg <= ST_OFF;
			cnt_reg <= 2'h0;
			rot_reg <= 2'h0;
			comp_out <= 1'b0;
			stage_out <= 3'h0;
			analog_out <= `RST_ZERO16;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			rot_reg <= rot_next;
			comp_out <= (state_next != ST_OFF);
			stage_out <= stage_on;
			case (func_reg)
			`FUNC_SEQ: analog_out <= {5'h00, vern};
			`FUNC_COMP: analog_out <= `RST_ZERO16;
			default: analog_out <= in_a;
			endcase
		end
	end

endmodule // special_output

// >>> logic/special_output_defines.vh
`ifndef SPECIAL_OUTPUT_DEFINES_VH
`define SPECIAL_OUTPUT_DEFINES_VH

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define SECOND_NS 1000000000
`define SECOND_CYCLES (`SECOND_NS / `CLK_PERIOD_NS)

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define OFS_CTRL 8'h00
`define OFS_A_ON 8'h04
`define OFS_A_OFF 8'h08
`define OFS_B_ON 8'h0C
`define OFS_B_OFF 8'h10
`define OFS_MIN_ON 8'h14
`define OFS_MIN_OFF 8'h18
`define OFS_OFF_DLY 8'h1C
`define OFS_ZERO_TMO 8'h20
`define OFS_SIZE1 8'h24
`define OFS_SIZE2 8'h28
`define OFS_SIZE3 8'h2C
`define OFS_SIZE4 8'h30
`define OFS_STAGE_DLY 8'h34
`define OFS_STATUS 8'h38

// ----------------------------------------------------------------------
// control fields and encodings
// ----------------------------------------------------------------------
`define CTRL_FUNC_LSB 0
`define CTRL_ORDER_BIT 4
`define CTRL_B_CONN_BIT 8
`define FUNC_OFF 2'h0
`define FUNC_COMP 2'h1
`define FUNC_SEQ 2'h2

// ----------------------------------------------------------------------
// status fields
// ----------------------------------------------------------------------
`define STAT_COMP_BIT 0
`define STAT_DLY_BIT 1
`define STAT_CNT_LSB 4
`define STAT_ROT_LSB 8
`define STAT_STAGE_LSB 12

// ----------------------------------------------------------------------
// reset values and scaling
// ----------------------------------------------------------------------
`define RST_ZERO16 16'h0000
`define RST_ZERO14 14'h0000
`define RST_ZERO17 17'h00000
`define PCT_FULL 11'h3E8

`endif

// >>> logic/tick_gen.v
`timescale 1ns/1ns

// one-cycle pulse once per timebase period; all timers count these
module tick_gen #(
	parameter TICK_CYCLES = 100000000
) (
	input wire mclk,
	input wire reset,
	output reg tick
);

	reg [31:0] div_reg;

	// ------------------------------------------------------------------
	// free-running divider
	// ------------------------------------------------------------------
	always @(posedge mclk) begin
		if (reset) begin
			div_reg <= 32'h00000000;
			tick <= 1'b0;
		end else if (div_reg >= TICK_CYCLES - 1) begin
			div_reg <= 32'h00000000;
			tick <= 1'b1;
		end else begin
			div_reg <= div_reg + 32'h00000001;
			tick <= 1'b0;
		end
	end

endmodule // tick_gen

// >>> tb/loop_source.sv
`timescale 1ns/1ns

// ---------------------------------------------------------------
// upstream control loops
// ---------------------------------------------------------------
// registers the commanded demands so the block only ever sees clean
// levels that change just after an edge
module loop_source (
	input wire mclk,
	input wire signed [15:0] dem_a,
	input wire signed [15:0] dem_b,
	output reg signed [15:0] in_a = 16'h0000,
	output reg signed [15:0] in_b = 16'h0000
);
	always @(posedge mclk) begin
		in_a <= dem_a;
		in_b <= dem_b;
	end
endmodule // loop_source

// >>> tb/special_output_chk.sv
`timescale 1ns/1ns

module special_output_chk #(
	parameter TICK_CYCLES = 10
) (
	input wire mclk,
	input wire reset,
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [31:0] reg_rdata,
	input wire signed [15:0] in_a,
	input wire signed [15:0] in_b,
	input wire signed [15:0] analog_out,
	input wire [2:0] stage_out,
	input wire comp_out
);
	reg [1:0] func_q;
	reg b_conn_q;
	reg signed [15:0] a_on_q;
	reg signed [15:0] b_on_q;
	reg [13:0] min_on_q;
	reg [31:0] on_cnt;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	// ---------------------------------------------------------------
	// shadow settings
	// ---------------------------------------------------------------
	// copies taken off the write strobe, so the checker never peeks inside
	always @(posedge mclk) begin
		if (reset) begin
			func_q <= 2'h0;
			b_conn_q <= 1'b0;
			a_on_q <= 16'h0000;
			b_on_q <= 16'h0000;
			min_on_q <= 14'h0000;
		end else if (reg_wr) begin
			case (reg_addr)
			8'h00: begin
				func_q <= reg_wdata[1:0];
				b_conn_q <= reg_wdata[8];
			end
			8'h04: a_on_q <= reg_wdata[15:0];
			8'h0C: b_on_q <= reg_wdata[15:0];
			8'h14: min_on_q <= reg_wdata[13:0];
			default: ;
			endcase
		end
	end
	// length of the current run; a tick may land early, so one period is allowed
	always @(posedge mclk) begin
		on_cnt <= (reset || !comp_out) ? 32'h0 : on_cnt + 32'h1;
	end
	a_call_cause: assert property ($rose(comp_out) |->
		$past(in_a) <= $past(a_on_q) || ($past(b_conn_q) && $past(in_b) <= $past(b_on_q)))
		else $error("compressor started without a call");
	a_b_ignored: assert property ($rose(comp_out) && !$past(b_conn_q) |->
		$past(in_a) <= $past(a_on_q)) else $error("unconnected input started compressor");
	a_min_on_hold: assert property ($fell(comp_out) && func_q == 2'h1 |->
		$past(on_cnt) + TICK_CYCLES + 1 >= min_on_q * TICK_CYCLES)
		else $error("compressor run shorter than minimum on time");
	a_comp_mode: assert property (comp_out |-> $past(func_q) == 2'h1)
		else $error("compressor on outside compressor mode");
	a_stage_mode: assert property (stage_out != 3'h0 |-> $past(func_q) == 2'h2)
		else $error("stage on outside sequencer mode");
	a_off_copy: assert property (func_q == 2'h0 && $past(func_q) == 2'h0 && !$past(reset) |->
		analog_out == $past(in_a) && stage_out == 3'h0 && !comp_out)
		else $error("off mode output wrong");
	a_vernier_span: assert property (func_q == 2'h2 && $past(func_q) == 2'h2 |->
		analog_out >= 16'sh0000 && analog_out <= 16'sh03E8) else $error("vernier out of span");
	a_stage_drop: assert property ((func_q == 2'h2 && in_a <= 16'sh0000) [*8] |->
		stage_out == 3'h0) else $error("stages on with no demand");
	cover property ($rose(comp_out));
	cover property ($fell(comp_out) && func_q == 2'h1);
	cover property (stage_out == 3'h7);
endmodule // special_output_chk

bind special_output special_output_chk #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.mclk(mclk),
	.reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_a(in_a), .in_b(in_b),
	.analog_out(analog_out), .stage_out(stage_out), .comp_out(comp_out));

// >>> tb/test_compressor_and_sequencer_output.sv
`timescale 1ns/1ns

module test_compressor_and_sequencer_output;
	reg mclk = 1'b0;
	reg reset = 1'b1;
	reg [7:0] reg_addr = 8'h00;
	reg [31:0] reg_wdata = 32'h0;
	reg reg_wr = 1'b0;
	reg reg_rd = 1'b0;
	reg signed [15:0] dem_a = 16'h0000;
	reg signed [15:0] dem_b = 16'h0000;
	wire signed [15:0] in_a;
	wire signed [15:0] in_b;
	wire signed [15:0] analog_out;
	wire [31:0] reg_rdata;
	wire [2:0] stage_out;
	wire comp_out;
	reg [31:0] n_fail = 32'h0;
	reg [31:0] samples_checked = 32'h0;
	reg [31:0] n;
	reg [31:0] m;
	always #5 mclk = ~mclk;
	loop_source src_u (.mclk(mclk), .dem_a(dem_a), .dem_b(dem_b), .in_a(in_a), .in_b(in_b));
	// short timebase: one second is ten clocks here
	special_output #(.TICK_CYCLES(10)) dut_u (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.in_a(in_a), .in_b(in_b), .analog_out(analog_out), .stage_out(stage_out),
		.comp_out(comp_out));
	// ---------------------------------------------------------------
	// access and checking tasks
	// ---------------------------------------------------------------
	task check(input [31:0] seen, input [31:0] exp);
		begin
			samples_checked = samples_checked + 1;
			if (seen !== exp) begin
				n_fail = n_fail + 1;
				$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask
	task give_verdict;
		begin
			$display("checks=%0d mismatches=%0d", samples_checked, n_fail);
			if (n_fail == 0 && samples_checked != 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask
	// a strobe is always dropped for one edge before the next one rises
	task wr(input [7:0] a, input [31:0] d);
		begin
			@(posedge mclk);
			reg_wr <= 1'b1;
			reg_addr <= a;
			reg_wdata <= d;
			@(posedge mclk);
			reg_wr <= 1'b0;
		end
	endtask
	task rd(input [7:0] a, input [31:0] exp);
		begin
			@(posedge mclk);
			reg_rd <= 1'b1;
			reg_addr <= a;
			@(posedge mclk);
			reg_rd <= 1'b0;
			#1 check(reg_rdata, exp);
		end
	endtask
	// sel 0 compressor, 1 stages, 2 vernier; cyc returns the cycles waited
	task wait_sig(input [1:0] sel, input [31:0] exp, output [31:0] cyc);
		reg [31:0] v;
		begin
			cyc = 32'h0;
			v = ~exp;
			while (v !== exp && cyc < 32'h190) begin
				@(posedge mclk);
				#1 cyc = cyc + 1;
				v = (sel == 2'h0) ? {31'h0, comp_out} : (sel == 2'h1) ? {29'h0, stage_out} :
					{{16{analog_out[15]}}, analog_out};
			end
			check(v, exp);
			if (v !== exp)
				give_verdict;
		end
	endtask
	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		repeat (4) @(posedge mclk);
		reset <= 1'b0;
		rd(8'h04, 32'h0);
		wr(8'h04, 32'hFFFFFFEC);
		rd(8'h04, 32'hFFFFFFEC);
		wr(8'h38, 32'hFFFFFFFF);
		rd(8'h38, 32'h0);
		rd(8'h3C, 32'h0);
		dem_a <= 16'h0159;
		repeat (3) @(posedge mclk);
		#1 check(analog_out, 32'h159);
		// single loop: B left unconnected but showing a strong call
		wr(8'h08, 32'h14);
		wr(8'h14, 32'h3);
		wr(8'h18, 32'h2);
		wr(8'h1C, 32'h5);
		dem_a <= 16'h0064;
		dem_b <= 16'hFDA8;
		wr(8'h00, 32'h1);
		repeat (40) @(posedge mclk);
		#1 check(comp_out, 32'h0);
		dem_a <= 16'hFFE2;
		wait_sig(2'h0, 32'h1, n);
		check(n <= 32'h3, 32'h1);
		dem_a <= 16'h0064;
		repeat (15) @(posedge mclk);
		#1 check(comp_out, 32'h1);
		wait_sig(2'h0, 32'h0, m);
		check(m >= 32'h2D && m <= 32'h4B, 32'h1);
		dem_a <= 16'hFFE2;
		wait_sig(2'h0, 32'h1, n);
		check(n >= 32'hA, 32'h1);
		// renewed demand inside the off delay; zero power with timeout disabled
		dem_a <= 16'h0064;
		repeat (35) @(posedge mclk);
		dem_a <= 16'h0000;
		repeat (60) @(posedge mclk);
		#1 check(comp_out, 32'h1);
		// sitting exactly on turn-off already counts as no demand
		dem_a <= 16'h0014;
		wait_sig(2'h0, 32'h0, m);
		check(m >= 32'h28, 32'h1);
		wr(8'h20, 32'h2);
		dem_a <= 16'hFFE2;
		wait_sig(2'h0, 32'h1, n);
		dem_a <= 16'h0000;
		wait_sig(2'h0, 32'h0, m);
		check(m >= 32'h14, 32'h1);
		// two loops
		wr(8'h0C, 32'hFFFFFFCE);
		wr(8'h10, 32'h32);
		dem_a <= 16'h0064;
		dem_b <= 16'h0064;
		wr(8'h00, 32'h101);
		dem_b <= 16'hFFC4;
		wait_sig(2'h0, 32'h1, n);
		dem_b <= 16'h0000;
		repeat (100) @(posedge mclk);
		#1 check(comp_out, 32'h1);
		dem_a <= 16'h0000;
		wait_sig(2'h0, 32'h0, m);
		// sequencer: vernier 100, stages 50 each
		wr(8'h24, 32'h64);
		wr(8'h28, 32'h32);
		wr(8'h2C, 32'h32);
		wr(8'h30, 32'h32);
		wr(8'h00, 32'h2);
		dem_a <= 16'h01F4;
		wait_sig(2'h1, 32'h3, n);
		wait_sig(2'h2, 32'hFA, n);
		dem_a <= 16'h03E8;
		wait_sig(2'h1, 32'h7, n);
		wait_sig(2'h2, 32'h3E8, n);
		// status: all three stages on, count three, no rotation
		rd(8'h38, 32'h7030);
		dem_a <= 16'h07D0;
		repeat (5) @(posedge mclk);
		#1 check(analog_out, 32'h3E8);
		wr(8'h34, 32'h2);
		dem_a <= 16'h0000;
		wait_sig(2'h1, 32'h0, n);
		// keep zero demand a while so the stage drop watch gets exercised
		repeat (10) @(posedge mclk);
		dem_a <= 16'h03E8;
		wait_sig(2'h1, 32'h7, n);
		check(n >= 32'h14, 32'h1);
		dem_a <= 16'h0000;
		wait_sig(2'h1, 32'h0, n);
		dem_a <= 16'h00C8;
		wait_sig(2'h1, 32'h1, n);
		// progressive order: the first stage moves between two runs
		wr(8'h00, 32'h12);
		dem_a <= 16'h0000;
		wait_sig(2'h1, 32'h0, n);
		dem_a <= 16'h00C8;
		repeat (30) @(posedge mclk);
		#1 m = {29'h0, stage_out};
		dem_a <= 16'h0000;
		wait_sig(2'h1, 32'h0, n);
		dem_a <= 16'h00C8;
		repeat (30) @(posedge mclk);
		#1 check(m[2:0] !== stage_out, 32'h1);
		wr(8'h00, 32'h0);
		repeat (3) @(posedge mclk);
		#1 check(stage_out, 32'h0);
		// the spare selector code behaves as off
		wr(8'h00, 32'h3);
		repeat (3) @(posedge mclk);
		#1 check(analog_out, 32'hC8);
		check(stage_out, 32'h0);
		give_verdict;
	end
endmodule // test_compressor_and_sequencer_output
